// [tcpd_params.svh]
`ifndef TCPD_PARAMS_SVH
`define TCPD_PARAMS_SVH

// Framing and limits of a host packet.
`define TCPD_SOH        8'h01
`define TCPD_ETB        8'h17
`define TCPD_MAX_BYTES  6'h28
`define TCPD_LAST_IDX   6'h26

// Packet identifiers and field characters.
`define TCPD_ID_DAC     8'h44
`define TCPD_ID_HB      8'h46
`define TCPD_ID_DELAY   8'h47
`define TCPD_ID_FMT     8'h48
`define TCPD_ID_SRC     8'h49
`define TCPD_ID_GEN     8'h4B
`define TCPD_HB_SYNC    8'h35
`define TCPD_HB_ASYNC   8'h32
`define TCPD_CH_MINUS   8'h2D
`define TCPD_CH_PLUS    8'h2B
`define TCPD_SRC_EXT    8'h45
`define TCPD_SRC_INT    8'h49
`define TCPD_FMT_A      8'h41
`define TCPD_FMT_B      8'h42
`define TCPD_FMT_C      8'h43
`define TCPD_FMT_N      8'h4E
`define TCPD_FMT_X      8'h58
`define TCPD_MOD_AM     8'h4D
`define TCPD_MOD_DC     8'h44
`define TCPD_GEN_B      8'h42
`define TCPD_GEN_H      8'h48
`define TCPD_CH_0       8'h30
`define TCPD_CH_9       8'h39
`define TCPD_CH_A       8'h41
`define TCPD_CH_F       8'h46
`define TCPD_HEX_OFS    4'h9

// Byte counts after the start byte, identifier included, terminator excluded.
`define TCPD_LEN_DAC    6'h05
`define TCPD_LEN_HB     6'h0A
`define TCPD_LEN_DELAY  6'h09
`define TCPD_LEN_FMT    6'h03
`define TCPD_LEN_ONE    6'h02
`define TCPD_DEC_DIGITS 7

// Timing.
`define TCPD_CLK_NS       25
`define TCPD_TICK_NS      100
`define TCPD_CLK_PER_TICK (`TCPD_TICK_NS / `TCPD_CLK_NS)
`define TCPD_JAM_NS       1000000
`define TCPD_JAM_TICKS    (`TCPD_JAM_NS / `TCPD_TICK_NS)

// Reset values.
`define TCPD_DAC_RESET  16'h8000
`define TCPD_DIV_RESET  16'h0009

`endif

// [tcpd_pkg.sv]
package tcpd_pkg;
  typedef enum logic [2:0] {
    TCPD_S_IDLE    = 3'b000,
    TCPD_S_SOH     = 3'b001,
    TCPD_S_COLLECT = 3'b010,
    TCPD_S_EXEC    = 3'b011,
    TCPD_S_FINISH  = 3'b100
  } tcpd_state_t;

  typedef struct packed {
    logic        hb_sync;
    logic [15:0] first_divisor;
    logic [15:0] second_divisor;
    logic        delay_retard;
    logic [23:0] delay;
    logic [7:0]  code_format;
    logic [7:0]  code_modulation;
    logic [7:0]  gen_code;
    logic        clk_ext;
  } tcpd_cfg_t;
endpackage

// [tcpd_heartbeat.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcpd_params.svh"

module tcpd_heartbeat
  import tcpd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tick,
  input  wire logic        epoch,
  input  wire logic        sync_mode,
  input  wire logic [15:0] first_divisor,
  input  wire logic [15:0] second_divisor,
  output logic             hb
);
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [15:0] reload1;
  logic [15:0] reload2;
  logic        wrap1;

  // Synchronous mode counts value down to zero, one state more than asynchronous.
  assign reload1 = sync_mode ? first_divisor : first_divisor - 16'h0001;
  assign reload2 = sync_mode ? second_divisor : second_divisor - 16'h0001;
  assign wrap1   = tick && (cnt1 == 16'h0000);
  assign hb      = wrap1 && (cnt2 == 16'h0000);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt1 <= 16'h0000;
    end else if (ce) begin
      if (sync_mode && epoch) begin
        cnt1 <= reload1;
      end else if (wrap1) begin
        cnt1 <= reload1;
      end else if (tick) begin
        cnt1 <= cnt1 - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt2 <= 16'h0000;
    end else if (ce) begin
      if (sync_mode && epoch) begin
        cnt2 <= reload2;
      end else if (wrap1) begin
        cnt2 <= (cnt2 == 16'h0000) ? reload2 : cnt2 - 16'h0001;
      end
    end
  end
endmodule

`default_nettype wire

// [tcpd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcpd_params.svh"

module tcpd_decoder
  import tcpd_pkg::*;
#(
  parameter int PPS_TICKS = 32'h0098_9680
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        pkt_req,
  input  wire logic        ack_clear,
  input  wire logic        fifo_valid,
  input  wire logic [7:0]  fifo_data,
  input  wire logic        disc_en,
  input  wire logic        jam_en,
  input  wire logic        ext_ref,
  input  wire logic        ref_pps,
  output logic             fifo_pop,
  output logic             fifo_clear,
  output logic             done,
  output logic             pkt_err,
  output logic [15:0]      dac_code,
  output logic             pps_out,
  output logic             hb_out,
  output tcpd_cfg_t        cfg
);
  tcpd_state_t state;
  logic [7:0]  pkt_buf [0:`TCPD_MAX_BYTES-1];
  logic [5:0]  idx;
  logic        take;
  logic [15:0] d_word;
  logic [15:0] div1_word;
  logic [15:0] div2_word;
  logic [23:0] dec_val;
  logic        exec;
  logic        pkt_ok;
  logic [7:0]  id;
  logic [1:0]  ext_sync;
  logic        ext_prev;
  logic [2:0]  ref_sync;
  logic [1:0]  div_cnt;
  logic        tick;
  logic [23:0] lc;
  logic [23:0] target;
  logic signed [25:0] diff;
  logic        ref_edge;
  logic        jam;
  logic        epoch;
  logic        hb;

  function automatic logic [3:0] hex_nib(input logic [7:0] c);
    if (c >= `TCPD_CH_A && c <= `TCPD_CH_F) begin
      return c[3:0] + `TCPD_HEX_OFS;
    end
    return (c >= `TCPD_CH_0 && c <= `TCPD_CH_9) ? c[3:0] : 4'h0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Packet collection.

  assign take = fifo_valid && !fifo_pop &&
                (state == TCPD_S_SOH || state == TCPD_S_COLLECT);
  assign exec = ce && (state == TCPD_S_EXEC);
  assign id   = pkt_buf[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= TCPD_S_IDLE;
      idx     <= 6'h00;
      pkt_err <= 1'b0;
    end else if (ce) begin
      case (state)
        TCPD_S_IDLE: begin
          if (pkt_req) begin
            state   <= TCPD_S_SOH;
            idx     <= 6'h00;
            pkt_err <= 1'b0;
          end
        end
        TCPD_S_SOH: begin
          if (take) begin
            state   <= (fifo_data == `TCPD_SOH) ? TCPD_S_COLLECT : TCPD_S_FINISH;
            pkt_err <= (fifo_data != `TCPD_SOH);
          end
        end
        TCPD_S_COLLECT: begin
          if (take) begin
            if (fifo_data == `TCPD_ETB) begin
              state <= TCPD_S_EXEC;
            end else if (idx == `TCPD_LAST_IDX) begin
              state   <= TCPD_S_FINISH;
              pkt_err <= 1'b1;
            end else begin
              idx <= idx + 6'h01;
            end
          end
        end
        TCPD_S_EXEC: begin
          state   <= TCPD_S_FINISH;
          pkt_err <= !pkt_ok;
        end
        TCPD_S_FINISH: state <= TCPD_S_IDLE;
        default:       state <= TCPD_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce && state == TCPD_S_COLLECT && take && fifo_data != `TCPD_ETB) begin
      pkt_buf[idx] <= fifo_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_pop   <= 1'b0;
      fifo_clear <= 1'b0;
      done       <= 1'b0;
    end else if (ce) begin
      fifo_pop   <= take;
      fifo_clear <= (state == TCPD_S_FINISH);
      // Completion wins over a host clear in the same cycle.
      done       <= (state == TCPD_S_FINISH) || (done && !ack_clear);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field assembly.

  assign d_word    = {hex_nib(pkt_buf[1]), hex_nib(pkt_buf[2]),
                      hex_nib(pkt_buf[3]), hex_nib(pkt_buf[4])};
  assign div1_word = {hex_nib(pkt_buf[2]), hex_nib(pkt_buf[3]),
                      hex_nib(pkt_buf[4]), hex_nib(pkt_buf[5])};
  assign div2_word = {hex_nib(pkt_buf[6]), hex_nib(pkt_buf[7]),
                      hex_nib(pkt_buf[8]), hex_nib(pkt_buf[9])};

  always_comb begin
    dec_val = 24'h00_0000;
    for (int k = 0; k < `TCPD_DEC_DIGITS; k++) begin
      dec_val = (dec_val << 3) + (dec_val << 1) + {20'h0_0000, pkt_buf[2+k][3:0]};
    end
  end

  always_comb begin
    case (id)
      `TCPD_ID_DAC:   pkt_ok = (idx == `TCPD_LEN_DAC);
      `TCPD_ID_HB:    pkt_ok = (idx == `TCPD_LEN_HB);
      `TCPD_ID_DELAY: pkt_ok = (idx == `TCPD_LEN_DELAY);
      `TCPD_ID_FMT:   pkt_ok = (idx == `TCPD_LEN_FMT);
      `TCPD_ID_SRC:   pkt_ok = (idx == `TCPD_LEN_ONE);
      `TCPD_ID_GEN:   pkt_ok = (idx == `TCPD_LEN_ONE);
      default:        pkt_ok = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration store. Mode, sign, format, source and generator bytes outside their set leave a field unchanged.

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg                 <= '0;
      cfg.first_divisor   <= `TCPD_DIV_RESET;
      cfg.second_divisor  <= `TCPD_DIV_RESET;
      cfg.hb_sync         <= 1'b1;
      cfg.code_format     <= `TCPD_FMT_B;
      cfg.code_modulation <= `TCPD_MOD_AM;
      cfg.gen_code        <= `TCPD_GEN_B;
      cfg.clk_ext         <= 1'b0;
    end else if (exec && pkt_ok) begin
      case (id)
        `TCPD_ID_HB: begin
          if (pkt_buf[1] == `TCPD_HB_SYNC || pkt_buf[1] == `TCPD_HB_ASYNC) begin
            cfg.hb_sync        <= (pkt_buf[1] == `TCPD_HB_SYNC);
            cfg.first_divisor  <= div1_word;
            cfg.second_divisor <= div2_word;
          end
        end
        `TCPD_ID_DELAY: begin
          if (pkt_buf[1] == `TCPD_CH_PLUS || pkt_buf[1] == `TCPD_CH_MINUS) begin
            cfg.delay_retard <= (pkt_buf[1] == `TCPD_CH_MINUS);
            cfg.delay        <= dec_val;
          end
        end
        `TCPD_ID_FMT: begin
          if ((pkt_buf[1] == `TCPD_FMT_A || pkt_buf[1] == `TCPD_FMT_B ||
               pkt_buf[1] == `TCPD_FMT_C || pkt_buf[1] == `TCPD_FMT_N ||
               pkt_buf[1] == `TCPD_FMT_X) &&
              (pkt_buf[2] == `TCPD_MOD_AM ||
               (pkt_buf[2] == `TCPD_MOD_DC && pkt_buf[1] != `TCPD_FMT_C &&
                pkt_buf[1] != `TCPD_FMT_X))) begin
            cfg.code_format     <= pkt_buf[1];
            cfg.code_modulation <= pkt_buf[2];
          end
        end
        `TCPD_ID_SRC: begin
          if (pkt_buf[1] == `TCPD_SRC_EXT || pkt_buf[1] == `TCPD_SRC_INT) begin
            cfg.clk_ext <= (pkt_buf[1] == `TCPD_SRC_EXT);
          end
        end
        `TCPD_ID_GEN: begin
          if (pkt_buf[1] == `TCPD_GEN_B || pkt_buf[1] == `TCPD_GEN_H) begin
            cfg.gen_code <= pkt_buf[1];
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference tick, local epoch and disciplining.

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
      ref_sync <= 3'b000;
      div_cnt  <= 2'b00;
    end else if (ce) begin
      ext_sync <= {ext_sync[0], ext_ref};
      ext_prev <= ext_sync[1];
      ref_sync <= {ref_sync[1:0], ref_pps};
      div_cnt  <= (div_cnt == 2'(`TCPD_CLK_PER_TICK - 1)) ? 2'b00 : div_cnt + 2'b01;
    end
  end

  assign tick = cfg.clk_ext ? (ext_sync[1] && !ext_prev)
                            : (div_cnt == 2'(`TCPD_CLK_PER_TICK - 1));
  assign epoch    = tick && (lc == 24'(PPS_TICKS - 1));
  assign ref_edge = ref_sync[1] && !ref_sync[2];
  assign target   = (cfg.delay == 24'h00_0000) ? 24'h00_0000 :
                    cfg.delay_retard ? 24'(PPS_TICKS) - cfg.delay : cfg.delay;

  always_comb begin
    diff = $signed({2'b00, lc}) - $signed({2'b00, target});
    if (diff > 26'(PPS_TICKS / 2)) begin
      diff = diff - 26'(PPS_TICKS);
    end else if (diff < -26'(PPS_TICKS / 2)) begin
      diff = diff + 26'(PPS_TICKS);
    end
  end

  assign jam = ref_edge && jam_en &&
               (diff > 26'(`TCPD_JAM_TICKS) || diff < -26'(`TCPD_JAM_TICKS));

  always_ff @(posedge clk) begin
    if (rst) begin
      lc <= 24'h00_0000;
    end else if (ce) begin
      if (jam) begin
        lc <= target;
      end else if (tick) begin
        lc <= epoch ? 24'h00_0000 : lc + 24'h00_0001;
      end
    end
  end

  // A direct load has priority over a loop step in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_code <= `TCPD_DAC_RESET;
    end else if (ce) begin
      if (exec && pkt_ok && id == `TCPD_ID_DAC) begin
        dac_code <= d_word;
      end else if (ref_edge && disc_en && !jam) begin
        if (diff > 26'sh000_0000 && dac_code != 16'h0000) begin
          dac_code <= dac_code - 16'h0001;
        end else if (diff < 26'sh000_0000 && dac_code != 16'hFFFF) begin
          dac_code <= dac_code + 16'h0001;
        end
      end
    end
  end

  tcpd_heartbeat u_hb (
    .clk            (clk),
    .rst            (rst),
    .ce             (ce),
    .tick           (tick),
    .epoch          (epoch),
    .sync_mode      (cfg.hb_sync),
    .first_divisor  (cfg.first_divisor),
    .second_divisor (cfg.second_divisor),
    .hb             (hb)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      pps_out <= 1'b0;
      hb_out  <= 1'b0;
    end else if (ce) begin
      pps_out <= epoch;
      hb_out  <= hb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_dac_direct_load: assert property (exec && pkt_ok && id == `TCPD_ID_DAC |=>
    dac_code == $past(d_word)) else $error("direct load not applied");
  a_clk_src_reset: assert property ($past(rst) |-> !cfg.clk_ext)
    else $error("reset did not select internal reference");
  a_hb_mode_sel: assert property (exec && pkt_ok && id == `TCPD_ID_HB &&
    pkt_buf[1] == `TCPD_HB_SYNC |=> cfg.hb_sync) else $error("sync mode not taken");
  a_fmt_dc_refused: assert property (exec && id == `TCPD_ID_FMT &&
    pkt_buf[1] == `TCPD_FMT_X && pkt_buf[2] == `TCPD_MOD_DC |=>
    $stable(cfg.code_modulation)) else $error("level shift accepted for X");
  a_soh_required: assert property (ce && state == TCPD_S_SOH && take &&
    fifo_data != `TCPD_SOH |=> state == TCPD_S_FINISH ##1 pkt_err && fifo_clear)
    else $error("missing start byte not discarded");
  a_bad_id_discard: assert property (exec && !pkt_ok |=> pkt_err)
    else $error("invalid packet not flagged");
  a_done_sets: assert property (ce && state == TCPD_S_FINISH |=> done && fifo_clear)
    else $error("done not set after packet");
  a_jam_load: assert property (ce && jam |=> lc == $past(target))
    else $error("jam did not load time base");
  a_steer_down: assert property (ce && ref_edge && disc_en && !jam && !exec &&
    diff > 26'sh000_0000 && dac_code != 16'h0000 |=>
    dac_code == $past(dac_code) - 16'h0001) else $error("steer down missed");

  c_dac_packet: cover property (exec && pkt_ok && id == `TCPD_ID_DAC);
  c_hb_packet:  cover property (exec && pkt_ok && id == `TCPD_ID_HB);
  c_discard:    cover property (state == TCPD_S_FINISH && pkt_err);
  c_jam:        cover property (ce && jam);
endmodule

`default_nettype wire

// [tcpd_host_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

// Host side of the input FIFO, first-word-fall-through, flushed on request.
module tcpd_host_fifo (
  input  wire logic       clk,
  input  wire logic       fifo_pop,
  input  wire logic       fifo_clear,
  output logic            fifo_valid,
  output logic [7:0]      fifo_data
);
  logic [7:0] mem [$];
  logic [7:0] last;

  // An empty FIFO shows the inverse of the last byte, never a stale copy.
  function automatic void refresh();
    fifo_valid = (mem.size() != 0);
    if (mem.size() != 0) begin
      fifo_data = mem[0];
      last = mem[0];
    end else begin
      fifo_data = ~last;
    end
  endfunction

  task automatic push(input logic [7:0] b);
    mem.push_back(b);
    refresh();
  endtask

  initial begin
    last = 8'h00;
    refresh();
  end

  always @(negedge clk) begin
    if (fifo_clear === 1'b1) begin
      mem.delete();
    end else if (fifo_pop === 1'b1 && mem.size() != 0) begin
      void'(mem.pop_front());
    end
    refresh();
  end
endmodule

`default_nettype wire

// [tb_timing_config_packet_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcpd_params.svh"

module tb_timing_config_packet_decoder
  import tcpd_pkg::*;
;
  localparam int PPS = 1000;
  logic        clk, rst, ce, pkt_req, ack_clear, disc_en, jam_en, ext_ref, ref_pps;
  logic        fifo_valid, fifo_pop, fifo_clear, done, pkt_err, pps_out, hb_out, ext_run;
  logic [7:0]  fifo_data;
  logic [15:0] dac_code;
  tcpd_cfg_t   cfg;
  logic [7:0]  q [$];
  int          fail_count, comparisons, gap, ext_div;
  logic [15:0] dac_tab [4] = '{16'h0123, 16'h4567, 16'h89AB, 16'hCDEF};
  logic [7:0]  fmt_tab [7][4] = '{
    '{`TCPD_FMT_A, `TCPD_MOD_AM, `TCPD_FMT_A, `TCPD_MOD_AM},
    '{`TCPD_FMT_N, `TCPD_MOD_DC, `TCPD_FMT_N, `TCPD_MOD_DC},
    '{`TCPD_FMT_B, `TCPD_MOD_DC, `TCPD_FMT_B, `TCPD_MOD_DC},
    '{`TCPD_FMT_C, `TCPD_MOD_DC, `TCPD_FMT_B, `TCPD_MOD_DC},
    '{`TCPD_FMT_X, `TCPD_MOD_DC, `TCPD_FMT_B, `TCPD_MOD_DC},
    '{`TCPD_FMT_C, `TCPD_MOD_AM, `TCPD_FMT_C, `TCPD_MOD_AM},
    '{`TCPD_FMT_X, `TCPD_MOD_AM, `TCPD_FMT_X, `TCPD_MOD_AM}};
  logic [7:0]  gen_tab [3][2] = '{'{`TCPD_GEN_H, `TCPD_GEN_H}, '{8'h51, `TCPD_GEN_H},
                                  '{`TCPD_GEN_B, `TCPD_GEN_B}};

  tcpd_decoder #(.PPS_TICKS(PPS)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .pkt_req(pkt_req), .ack_clear(ack_clear),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .disc_en(disc_en), .jam_en(jam_en),
    .ext_ref(ext_ref), .ref_pps(ref_pps), .fifo_pop(fifo_pop), .fifo_clear(fifo_clear),
    .done(done), .pkt_err(pkt_err), .dac_code(dac_code), .pps_out(pps_out),
    .hb_out(hb_out), .cfg(cfg));
  tcpd_host_fifo u_host (.clk(clk), .fifo_pop(fifo_pop), .fifo_clear(fifo_clear),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow stand-in for the external reference pin: one rising edge every ten clocks.
  always @(negedge clk) begin
    if (ext_run) begin
      ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
      if (ext_div == 4) ext_ref <= ~ext_ref;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? `TCPD_CH_0 + 8'(n) : `TCPD_CH_A - 8'h0A + 8'(n);
  endfunction

  task automatic send();
    int n;
    // Wait out the flush pulse of the previous packet before loading the FIFO.
    @(negedge clk);
    foreach (q[i]) u_host.push(q[i]);
    ack_clear = 1'b1;
    @(negedge clk);
    ack_clear = 1'b0;
    chk("done_cleared", 32'h0, 32'(done));
    pkt_req = 1'b1;
    @(negedge clk);
    pkt_req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("done", 32'h1, 32'(done));
  endtask

  task automatic send_err();
    send();
    chk("pkt_err", 32'h1, 32'(pkt_err));
    @(negedge clk);
    chk("fifo_flushed", 32'h0, 32'(fifo_valid));
  endtask

  task automatic load_dac(input logic [15:0] v);
    q = {`TCPD_SOH, `TCPD_ID_DAC, hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0]),
         `TCPD_ETB};
    send();
  endtask

  task automatic load_hb(input logic [7:0] m, input logic [15:0] a, input logic [15:0] b);
    q = {`TCPD_SOH, `TCPD_ID_HB, m, hx(a[15:12]), hx(a[11:8]), hx(a[7:4]), hx(a[3:0]),
         hx(b[15:12]), hx(b[11:8]), hx(b[7:4]), hx(b[3:0]), `TCPD_ETB};
    send();
  endtask

  task automatic load_delay(input logic [7:0] sign, input int v);
    q = {`TCPD_SOH, `TCPD_ID_DELAY, sign};
    for (int k = 6; k >= 0; k--) q.push_back(`TCPD_CH_0 + 8'((v / (10 ** k)) % 10));
    q.push_back(`TCPD_ETB);
    send();
    chk("delay", 32'(v), 32'(cfg.delay));
    chk("delay_retard", 32'(sign == `TCPD_CH_MINUS), 32'(cfg.delay_retard));
  endtask

  task automatic set_src(input logic [7:0] s, input logic e);
    q = {`TCPD_SOH, `TCPD_ID_SRC, s, `TCPD_ETB};
    send();
    chk("clk_ext", 32'(e), 32'(cfg.clk_ext));
  endtask

  task automatic hb_gap(output int g);
    int n;
    n = 0;
    while (hb_out !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (hb_out !== 1'b1 && g < 5000);
  endtask

  task automatic wait_pps();
    int n;
    n = 0;
    while (pps_out !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(60000 * 25);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    results();
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    {rst, ce} = 2'b11;
    {pkt_req, ack_clear, ext_ref, ref_pps, ext_run, ext_div} = '0;
    disc_en = 1'b0;
    jam_en = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("dac_reset", 32'(`TCPD_DAC_RESET), 32'(dac_code));
    chk("clk_ext_reset", 32'h0, 32'(cfg.clk_ext));
    $display("test reset complete");
    foreach (dac_tab[i]) begin
      load_dac(dac_tab[i]);
      chk("dac_code", 32'(dac_tab[i]), 32'(dac_code));
      chk("pkt_err", 32'h0, 32'(pkt_err));
    end
    $display("test converter load complete");
    load_hb(`TCPD_HB_SYNC, 16'h0009, 16'h0063);
    chk("hb_sync", 32'h1, 32'(cfg.hb_sync));
    chk("first_divisor", 32'h9, 32'(cfg.first_divisor));
    chk("second_divisor", 32'h63, 32'(cfg.second_divisor));
    load_hb(`TCPD_HB_SYNC, 16'h0003, 16'h0004);
    wait_pps();
    hb_gap(gap);
    hb_gap(gap);
    chk("sync_gap", 32'(4 * 5 * `TCPD_CLK_PER_TICK), 32'(gap));
    load_hb(`TCPD_HB_ASYNC, 16'h0003, 16'h0002);
    chk("hb_async", 32'h0, 32'(cfg.hb_sync));
    hb_gap(gap);
    hb_gap(gap);
    chk("async_gap", 32'(3 * 2 * `TCPD_CLK_PER_TICK), 32'(gap));
    @(negedge clk);
    ce = 1'b0;
    gap = 0;
    repeat (100) begin
      @(negedge clk);
      if (hb_out === 1'b1) gap++;
    end
    chk("ce_freeze", 32'h0, 32'(gap));
    ce = 1'b1;
    $display("test heartbeat complete");
    set_src(`TCPD_SRC_EXT, 1'b1);
    ext_run = 1'b1;
    hb_gap(gap);
    hb_gap(gap);
    chk("ext_gap", 32'(3 * 2 * 10), 32'(gap));
    ext_run = 1'b0;
    repeat (20) @(negedge clk);
    gap = 0;
    repeat (300) begin
      @(negedge clk);
      if (hb_out === 1'b1) gap++;
    end
    chk("ext_still", 32'h0, 32'(gap));
    set_src(8'h51, 1'b1);
    set_src(`TCPD_SRC_INT, 1'b0);
    $display("test clock source complete");
    load_delay(`TCPD_CH_MINUS, 9999999);
    load_delay(`TCPD_CH_PLUS, 1234567);
    load_delay(`TCPD_CH_PLUS, 0);
    $display("test delay complete");
    foreach (fmt_tab[i]) begin
      q = {`TCPD_SOH, `TCPD_ID_FMT, fmt_tab[i][0], fmt_tab[i][1], `TCPD_ETB};
      send();
      chk("code_format", 32'(fmt_tab[i][2]), 32'(cfg.code_format));
      chk("code_modulation", 32'(fmt_tab[i][3]), 32'(cfg.code_modulation));
    end
    foreach (gen_tab[i]) begin
      q = {`TCPD_SOH, `TCPD_ID_GEN, gen_tab[i][0], `TCPD_ETB};
      send();
      chk("gen_code", 32'(gen_tab[i][1]), 32'(cfg.gen_code));
    end
    $display("test format and generator complete");
    q = {`TCPD_ID_DAC, hx(4'h1), hx(4'h2), hx(4'h3), hx(4'h4), `TCPD_ETB};
    send_err();
    q = {`TCPD_SOH, 8'h5A, `TCPD_ETB};
    send_err();
    q = {`TCPD_SOH, `TCPD_ID_DAC, hx(4'h1), hx(4'h2), `TCPD_ETB};
    send_err();
    q = {`TCPD_SOH};
    repeat (44) q.push_back(`TCPD_CH_0);
    send_err();
    chk("dac_kept", 32'(dac_tab[3]), 32'(dac_code));
    load_dac(16'h8000);
    chk("pkt_err_clear", 32'h0, 32'(pkt_err));
    $display("test discard complete");
    disc_en = 1'b1;
    wait_pps();
    repeat (400) @(negedge clk);
    ref_pps = 1'b1;
    repeat (8) @(negedge clk);
    ref_pps = 1'b0;
    chk("dac_steer", 32'h7FFF, 32'(dac_code));
    disc_en = 1'b0;
    $display("test disciplining complete");
    results();
  end
endmodule

`default_nettype wire
